// ---- hdl/ofc_params.svh ----
// constants for the output module fail-safe control link and modes
// Notes on behaviour
// - powered-off: no function, no data, no configuration
// - power applied: powered-off goes to startup
// - power lost from any mode: powered-off
// - error code sticky until power-off or higher
// - command silence: safe-run, safe request, channels safe; a unit in config mode stays in config with no safe request
// - supply or config memory failure: faulted, outputs safe
// - controller: no response, broadcast trip flag
// - trip flag: safe request plus per-channel safe; a unit in config mode stays in config with no safe request
// - internal failure stops heartbeat toggling
// - channel failure reported to controller and panel
// - controller forces failed channels to safe
// - controller substitutes safe values during trip
// - controller flags lost unit communication
// - 32 channels, safe state open contact
// - exchange every 5 ms, diagnostics no slower
// - 100 Mbit/s redundant links, CRC checked
// - run and fault LEDs, 4-character display
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH
`define OFC_CLK_MHZ     100
`define OFC_LINK_MBPS   100
`define OFC_EXCH_MS     5
`define OFC_EXCH_CYC    (`OFC_EXCH_MS * 1000 * `OFC_CLK_MHZ)
`define OFC_TMO_EXCH    3
`define OFC_HB_CYC      1000
`define OFC_NCHAN       32
`define OFC_NLINK       2
`define OFC_FRM_BITS    48
`define OFC_CRC_POLY    8'h07
`define OFC_TYP_CMD     8'h01
`define OFC_TYP_TRIP    8'h02
`define OFC_TYP_STAT    5'h02
`define OFC_CHAN_SAFE   1'b0
`define OFC_ERR_NONE    3'h0
`define OFC_ERR_CHAN    3'h1
`define OFC_ERR_COMM    3'h2
`define OFC_ERR_TRIP    3'h3
`define OFC_ERR_INT     3'h4
`define OFC_ERR_SUPPLY  3'h5
`define OFC_TXT_OFF     32'h4F46_4620
`define OFC_TXT_STRT    32'h5354_5254
`define OFC_TXT_RUN     32'h5255_4E20
`define OFC_TXT_SAFE    32'h5341_4645
`define OFC_TXT_FLT     32'h464C_5420
`define OFC_TXT_CONF    32'h434F_4E46
`define OFC_TXT_ERR     24'h4552_20
`define OFC_TXT_DIG     8'h30
`endif

// ---- hdl/ofc_pkg.sv ----
// types and frame check shared by both ends of the link
`include "ofc_params.svh"
package ofc_pkg;
   typedef enum logic [2:0] {
      OFC_OFF     = 3'h0,
      OFC_STARTUP = 3'h1,
      OFC_RUN     = 3'h3,
      OFC_SAFE    = 3'h2,
      OFC_FAULT   = 3'h6,
      OFC_CONFIG  = 3'h7
   } ofc_mode_e;

   typedef logic [`OFC_FRM_BITS-1:0] ofc_frame_t;

   // frame is {type[7:0], payload[31:0], crc[7:0]}; status frames hold type[4:0] and mode[2:0] in the top byte
   function automatic logic [7:0] ofc_crc8(input logic [39:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 39; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `OFC_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction
endpackage

// ---- hdl/ofc_link_if.sv ----
// redundant serial link pair between controller and output unit
`timescale 1ns/1ps
interface ofc_link_if;
   logic [1:0] c2u_bit;
   logic [1:0] c2u_frm;
   logic [1:0] u2c_bit;
   logic [1:0] u2c_frm;
   modport ctrl (output c2u_bit, output c2u_frm, input u2c_bit, input u2c_frm);
   modport unit (input c2u_bit, input c2u_frm, output u2c_bit, output u2c_frm);
endinterface

// ---- hdl/ofc_unit.sv ----
// output unit end: mode sequencing, fail-safe outputs, status and indication
`timescale 1ns/1ps
`include "ofc_params.svh"
module ofc_unit #(
   parameter int EXCH_CYC = `OFC_EXCH_CYC,
   parameter int TMO_CYC  = `OFC_TMO_EXCH * `OFC_EXCH_CYC,
   parameter int HB_CYC   = `OFC_HB_CYC
) (
   input  wire logic              i_clk,           // module clock
   input  wire logic              i_reset,         // power-on reset
   ofc_link_if.unit               link,            // redundant link pair
   input  wire logic              i_power_good,    // module energized
   input  wire logic              i_supply_fail,   // supervisor: supply or config memory failure
   input  wire logic              i_internal_fail, // high-level internal failure
   input  wire logic              i_config_req,    // request configuration mode
   input  wire logic [31:0]       i_chan_fail,     // per-channel failure
   output ofc_pkg::ofc_mode_e     o_mode,          // current mode
   output logic [31:0]            o_chan,          // channel commands, 1 closed
   output logic                   o_safe_output_request, // global safe request
   output logic                   o_heartbeat,     // toggling heartbeat
   output logic                   o_led_run,       // run LED
   output logic                   o_led_fault,     // fault LED
   output logic [31:0]            o_display,       // four ASCII characters
   output logic [2:0]             o_err            // sticky error code
);
   import ofc_pkg::*;

   localparam int CW = 32;

   ofc_mode_e        mode;
   ofc_mode_e        next_mode;
   ofc_frame_t       rx_sr [`OFC_NLINK];
   logic [5:0]       rx_cnt [`OFC_NLINK];
   logic [1:0]       rx_good;
   logic             rx_ok;
   ofc_frame_t       rx_frame;
   logic             got_cmd;
   logic             got_trip;
   logic [CW-1:0]    silence;
   logic             comm_loss;
   logic [2:0]       next_err;
   logic             hb_stop;
   logic [CW-1:0]    hb_cnt;
   logic [31:0]      failed;
   ofc_frame_t       tx_sr;
   logic [5:0]       tx_cnt;
   logic             tx_busy;
   logic             reply_pend;
   logic [CW-1:0]    diag_cnt;
   logic             tx_start;
   logic [39:0]      tx_body;

   // per-link deserialiser; a frame ends when its frame line drops
   for (genvar l = 0; l < `OFC_NLINK; l++) begin : g_rx
      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            rx_sr[l]  <= '0;
            rx_cnt[l] <= 6'h00;
         end else if (link.c2u_frm[l]) begin
            rx_sr[l]  <= {rx_sr[l][`OFC_FRM_BITS-2:0], link.c2u_bit[l]};
            rx_cnt[l] <= rx_cnt[l] + 6'h01;
         end else begin
            rx_cnt[l] <= 6'h00;
         end
      end
      assign rx_good[l] = !link.c2u_frm[l] && (rx_cnt[l] == 6'(`OFC_FRM_BITS)) &&
                          (ofc_crc8(rx_sr[l][47:8]) == rx_sr[l][7:0]);
   end

   assign rx_ok    = (|rx_good) && (mode != OFC_OFF);
   assign rx_frame = rx_good[0] ? rx_sr[0] : rx_sr[1];
   assign got_cmd  = rx_ok && (rx_frame[47:40] == `OFC_TYP_CMD);
   assign got_trip = rx_ok && (rx_frame[47:40] == `OFC_TYP_TRIP);

   // silence counter since the last valid frame
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         silence <= '0;
      end else if (rx_ok || mode == OFC_OFF) begin
         silence <= '0;
      end else if (silence < CW'(TMO_CYC)) begin
         silence <= silence + 1'b1;
      end
   end
   assign comm_loss = (silence >= CW'(TMO_CYC));

   always_comb begin
      next_mode = mode;
      case (mode)
         OFC_OFF: begin
            if (i_power_good) begin
               next_mode = OFC_STARTUP;
            end
         end
         OFC_STARTUP: begin
            if (got_trip || comm_loss) begin
               next_mode = OFC_SAFE;
            end else if (got_cmd) begin
               next_mode = OFC_RUN;
            end
         end
         OFC_RUN: begin
            if (got_trip) begin
               next_mode = OFC_SAFE;
            end else if (comm_loss) begin
               next_mode = OFC_SAFE;
            end else if (i_config_req) begin
               next_mode = OFC_CONFIG;
            end
         end
         OFC_CONFIG: begin
            if (!i_config_req) begin
               next_mode = OFC_STARTUP;
            end
         end
         default: begin
            next_mode = mode;
         end
      endcase
      if (mode != OFC_OFF) begin
         if (!i_power_good) begin
            next_mode = OFC_OFF;
         end else if (i_supply_fail) begin
            next_mode = OFC_FAULT;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         mode <= OFC_OFF;
      end else begin
         mode <= next_mode;
      end
   end

   // each channel is commanded individually; only run passes commands
   for (genvar c = 0; c < `OFC_NCHAN; c++) begin : g_chan
      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            o_chan[c] <= `OFC_CHAN_SAFE;
         end else if (next_mode != OFC_RUN) begin
            o_chan[c] <= `OFC_CHAN_SAFE;
         end else if (got_cmd) begin
            o_chan[c] <= rx_frame[8 + c];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_safe_output_request <= 1'b0;
      end else begin
         o_safe_output_request <= (next_mode == OFC_SAFE) || (next_mode == OFC_FAULT);
      end
   end

   // highest pending cause; a higher code replaces a lower one only
   always_comb begin
      next_err = `OFC_ERR_NONE;
      if (i_supply_fail) begin
         next_err = `OFC_ERR_SUPPLY;
      end else if (i_internal_fail) begin
         next_err = `OFC_ERR_INT;
      end else if (got_trip) begin
         next_err = `OFC_ERR_TRIP;
      end else if (comm_loss && mode != OFC_CONFIG) begin
         next_err = `OFC_ERR_COMM;
      end else if (|i_chan_fail) begin
         next_err = `OFC_ERR_CHAN;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_err   <= `OFC_ERR_NONE;
         failed  <= 32'h0000_0000;
         hb_stop <= 1'b0;
      end else if (mode == OFC_OFF) begin
         o_err   <= `OFC_ERR_NONE;
         failed  <= 32'h0000_0000;
         hb_stop <= 1'b0;
      end else begin
         if (next_err > o_err) begin
            o_err <= next_err;
         end
         failed <= failed | i_chan_fail;
         if (i_internal_fail) begin
            hb_stop <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         hb_cnt      <= '0;
         o_heartbeat <= 1'b0;
      end else if (mode == OFC_OFF || hb_stop || i_internal_fail) begin
         hb_cnt <= '0;
      end else if (hb_cnt >= CW'(HB_CYC - 1)) begin
         hb_cnt      <= '0;
         o_heartbeat <= !o_heartbeat;
      end else begin
         hb_cnt <= hb_cnt + 1'b1;
      end
   end

   // status frame: reply to every command, and a diagnostic one after a period with no status frame sent
   assign tx_start = !tx_busy && (mode != OFC_OFF) && (reply_pend || diag_cnt >= CW'(EXCH_CYC - 1));
   assign tx_body  = {`OFC_TYP_STAT, mode, failed};

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tx_sr      <= '0;
         tx_cnt     <= 6'h00;
         tx_busy    <= 1'b0;
         reply_pend <= 1'b0;
         diag_cnt   <= '0;
      end else begin
         if (rx_ok) begin
            reply_pend <= 1'b1;
         end else if (tx_start) begin
            reply_pend <= 1'b0;
         end
         if (tx_start) begin
            tx_sr    <= {tx_body, ofc_crc8(tx_body)};
            tx_cnt   <= 6'h00;
            tx_busy  <= 1'b1;
            diag_cnt <= '0;
         end else begin
            if (diag_cnt < CW'(EXCH_CYC - 1)) begin
               diag_cnt <= diag_cnt + 1'b1;
            end
            if (tx_busy) begin
               tx_sr  <= {tx_sr[`OFC_FRM_BITS-2:0], 1'b0};
               tx_cnt <= tx_cnt + 6'h01;
               if (tx_cnt == 6'(`OFC_FRM_BITS - 1) || mode == OFC_OFF) begin
                  tx_busy <= 1'b0;
               end
            end
         end
      end
   end

   assign link.u2c_bit = {`OFC_NLINK{tx_sr[`OFC_FRM_BITS-1] & tx_busy}};
   assign link.u2c_frm = {`OFC_NLINK{tx_busy}};

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_led_run   <= 1'b0;
         o_led_fault <= 1'b0;
         o_display   <= `OFC_TXT_OFF;
      end else begin
         o_led_run   <= (mode == OFC_RUN);
         o_led_fault <= (o_err != `OFC_ERR_NONE) || (mode == OFC_FAULT);
         if (o_err != `OFC_ERR_NONE) begin
            o_display <= {`OFC_TXT_ERR, `OFC_TXT_DIG | {5'h00, o_err}};
         end else begin
            case (mode)
               OFC_STARTUP: o_display <= `OFC_TXT_STRT;
               OFC_RUN:     o_display <= `OFC_TXT_RUN;
               OFC_SAFE:    o_display <= `OFC_TXT_SAFE;
               OFC_FAULT:   o_display <= `OFC_TXT_FLT;
               OFC_CONFIG:  o_display <= `OFC_TXT_CONF;
               default:     o_display <= `OFC_TXT_OFF;
            endcase
         end
      end
   end

   assign o_mode = mode;
endmodule

// ---- hdl/ofc_ctrl.sv ----
// logic controller end: periodic commands, trip broadcast, safe substitution
`timescale 1ns/1ps
`include "ofc_params.svh"
module ofc_ctrl #(
   parameter int EXCH_CYC = `OFC_EXCH_CYC,
   parameter int TMO_CYC  = `OFC_TMO_EXCH * `OFC_EXCH_CYC
) (
   input  wire logic           i_clk,         // module clock
   input  wire logic           i_reset,       // power-on reset
   ofc_link_if.ctrl            link,          // redundant link pair
   input  wire logic [31:0]    i_cmd,         // application channel commands
   input  wire logic           i_trip_req,    // application trip request
   output logic                o_comm_loss,   // unit silent too long
   output logic                o_trip_flag,   // trip being broadcast
   output ofc_pkg::ofc_mode_e  o_unit_mode,   // last reported unit mode
   output logic [31:0]         o_chan_failed, // last reported failed channels
   output logic                o_safe_subst,  // safe substitution active
   output logic [31:0]         o_chan_eff     // commands after substitution
);
   import ofc_pkg::*;

   localparam int CW = 32;

   ofc_frame_t     rx_sr [`OFC_NLINK];
   logic [5:0]     rx_cnt [`OFC_NLINK];
   logic [1:0]     rx_good;
   ofc_frame_t     rx_frame;
   logic           got_stat;
   logic [CW-1:0]  silence;
   logic [CW-1:0]  per_cnt;
   ofc_frame_t     tx_sr;
   logic [5:0]     tx_cnt;
   logic           tx_busy;
   logic [39:0]    tx_body;

   for (genvar l = 0; l < `OFC_NLINK; l++) begin : g_rx
      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            rx_sr[l]  <= '0;
            rx_cnt[l] <= 6'h00;
         end else if (link.u2c_frm[l]) begin
            rx_sr[l]  <= {rx_sr[l][`OFC_FRM_BITS-2:0], link.u2c_bit[l]};
            rx_cnt[l] <= rx_cnt[l] + 6'h01;
         end else begin
            rx_cnt[l] <= 6'h00;
         end
      end
      assign rx_good[l] = !link.u2c_frm[l] && (rx_cnt[l] == 6'(`OFC_FRM_BITS)) &&
                          (ofc_crc8(rx_sr[l][47:8]) == rx_sr[l][7:0]);
   end

   assign rx_frame = rx_good[0] ? rx_sr[0] : rx_sr[1];
   assign got_stat = (|rx_good) && (rx_frame[47:43] == `OFC_TYP_STAT);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         silence       <= '0;
         o_unit_mode   <= OFC_OFF;
         o_chan_failed <= 32'h0000_0000;
      end else if (got_stat) begin
         silence       <= '0;
         o_unit_mode   <= ofc_mode_e'(rx_frame[42:40]);
         o_chan_failed <= rx_frame[39:8];
      end else if (silence < CW'(TMO_CYC)) begin
         silence <= silence + 1'b1;
      end
   end

   assign o_comm_loss = (silence >= CW'(TMO_CYC));
   assign o_trip_flag = o_comm_loss || i_trip_req;
   assign o_safe_subst = o_trip_flag || (o_unit_mode == OFC_SAFE) || (o_unit_mode == OFC_FAULT);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_chan_eff <= 32'h0000_0000;
      end else if (o_safe_subst) begin
         o_chan_eff <= {`OFC_NCHAN{`OFC_CHAN_SAFE}};
      end else begin
         o_chan_eff <= i_cmd & ~o_chan_failed;
      end
   end

   // one command or trip frame per exchange period on both links
   assign tx_body = {(o_trip_flag ? `OFC_TYP_TRIP : `OFC_TYP_CMD), o_chan_eff};

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         per_cnt <= '0;
         tx_sr   <= '0;
         tx_cnt  <= 6'h00;
         tx_busy <= 1'b0;
      end else begin
         if (per_cnt >= CW'(EXCH_CYC - 1)) begin
            per_cnt <= '0;
         end else begin
            per_cnt <= per_cnt + 1'b1;
         end
         if (!tx_busy && per_cnt >= CW'(EXCH_CYC - 1)) begin
            tx_sr   <= {tx_body, ofc_crc8(tx_body)};
            tx_cnt  <= 6'h00;
            tx_busy <= 1'b1;
         end else if (tx_busy) begin
            tx_sr  <= {tx_sr[`OFC_FRM_BITS-2:0], 1'b0};
            tx_cnt <= tx_cnt + 6'h01;
            if (tx_cnt == 6'(`OFC_FRM_BITS - 1)) begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   assign link.c2u_bit = {`OFC_NLINK{tx_sr[`OFC_FRM_BITS-1] & tx_busy}};
   assign link.c2u_frm = {`OFC_NLINK{tx_busy}};
endmodule

// ---- verif/ofc_tb_pkg.sv ----
// frame check helper shared by the link checker and the bench
`include "ofc_params.svh"
package ofc_tb_pkg;
   function automatic logic [7:0] crc8(input logic [39:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? `OFC_CRC_POLY : 8'h00);
      end
      return c;
   endfunction
endpackage

// ---- verif/ofc_sva.sv ----
// link checker: framing, redundancy and frame check in both directions, pacing of controller frames, minimum spacing of unit frames
`timescale 1ns/1ps
`include "ofc_params.svh"
module ofc_sva #(
   parameter int EXCH_CYC = 200
) (
   input wire logic       i_clk,   // module clock
   input wire logic       i_reset, // power-on reset
   input wire logic [1:0] c2u_bit, // controller to unit data
   input wire logic [1:0] c2u_frm, // controller to unit frame
   input wire logic [1:0] u2c_bit, // unit to controller data
   input wire logic [1:0] u2c_frm  // unit to controller frame
);
   import ofc_tb_pkg::*;
   // index 0 watches the controller side, index 1 the unit side
   wire logic [1:0] frm = {u2c_frm[0], c2u_frm[0]};
   wire logic [1:0] dat = {u2c_bit[0], c2u_bit[0]};
   logic [1:0]      frq;
   logic [1:0]      seen;
   logic [5:0]      cnt [2];
   logic [47:0]     sh [2];
   logic [15:0]     gap [2];
   wire logic [1:0] st = frm & ~frq;
   wire logic [1:0] fin = ~frm & frq;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         frq <= '0;
         seen <= '0;
         for (int i = 0; i < 2; i++) begin
            cnt[i] <= '0;
            sh[i] <= '0;
            gap[i] <= '0;
         end
      end else begin
         frq <= frm;
         seen <= seen | st;
         for (int i = 0; i < 2; i++) begin
            cnt[i] <= frm[i] ? cnt[i] + 6'h1 : 6'h0;
            sh[i] <= frm[i] ? {sh[i][46:0], dat[i]} : sh[i];
            gap[i] <= st[i] ? 16'h0001 : gap[i] + 16'(gap[i] != 16'hFFFF);
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_ctrl_frm_len: assert property (fin[0] |-> cnt[0] == 6'd48)
      else $error("controller frame length wrong");
   a_unit_frm_max: assert property (cnt[1] <= 6'd48)
      else $error("unit frame too long");
   a_ctrl_links_eq: assert property (c2u_frm[1] == c2u_frm[0] && (c2u_bit[1] == c2u_bit[0] || !c2u_frm[0]))
      else $error("controller links differ");
   a_unit_links_eq: assert property (u2c_frm[1] == u2c_frm[0] && (u2c_bit[1] == u2c_bit[0] || !u2c_frm[0]))
      else $error("unit links differ");
   a_ctrl_crc_ok: assert property (fin[0] |-> sh[0][7:0] == crc8(sh[0][47:8]))
      else $error("controller frame check wrong");
   a_unit_crc_ok: assert property (fin[1] && cnt[1] == 6'd48 |-> sh[1][7:0] == crc8(sh[1][47:8]))
      else $error("unit frame check wrong");
   a_ctrl_pace: assert property (st[0] && seen[0] |-> gap[0] >= 16'd49 && gap[0] <= 16'(EXCH_CYC))
      else $error("controller frame spacing wrong");
   a_unit_space: assert property (st[1] && seen[1] |-> gap[1] >= 16'd49)
      else $error("unit frames too close");
   a_unit_stat_type: assert property (fin[1] && cnt[1] == 6'd48 |-> sh[1][47:43] == `OFC_TYP_STAT)
      else $error("unit frame type wrong");
   a_ctrl_frm_type: assert property (fin[0] |-> sh[0][47:40] inside {`OFC_TYP_CMD, `OFC_TYP_TRIP})
      else $error("controller frame type wrong");
   c_trip_frame: cover property (fin[0] && sh[0][47:40] == `OFC_TYP_TRIP);
   c_unit_safe: cover property (fin[1] && sh[1][42:40] == 3'h2);
   c_chan_fail: cover property (fin[1] && sh[1][39:8] != 32'h0000_0000);
endmodule

// ---- verif/output_module_failsafe_ctrl_tb_top.sv ----
// bench: controller and unit back to back, plus a unit fed by a scripted far end
`timescale 1ns/1ps
`include "ofc_params.svh"
module output_module_failsafe_ctrl_tb_top;
   import ofc_pkg::*;
   import ofc_tb_pkg::*;
   logic        i_clk, i_reset, pg, sf, inf, cfg, trip, sor1, sor2, hb1, loss, tflag, subst, lr, lf;
   logic [31:0] cfail, cmd, chan1, chan2, disp1, failed, eff, mask, p;
   logic [2:0]  err1, err2;
   ofc_mode_e   mode1, mode2, umode;
   int          err_count = 0;
   int          compares = 0;
   int          n;
   localparam int EXCH = 200;
   localparam int TMO  = 700;
   localparam int HB   = 10;
   ofc_link_if link ();
   ofc_link_if link_b ();
   ofc_unit #(.EXCH_CYC(EXCH), .TMO_CYC(TMO), .HB_CYC(HB)) ofc_unit_inst (.i_clk(i_clk), .i_reset(i_reset),
      .link(link), .i_power_good(pg), .i_supply_fail(sf), .i_internal_fail(inf), .i_config_req(cfg),
      .i_chan_fail(cfail), .o_mode(mode1), .o_chan(chan1), .o_safe_output_request(sor1), .o_heartbeat(hb1),
      .o_led_run(lr), .o_led_fault(lf), .o_display(disp1), .o_err(err1));
   // far-end unit shares the fault inputs; they stay low until its own checks are done
   ofc_unit #(.EXCH_CYC(EXCH), .TMO_CYC(TMO), .HB_CYC(HB)) ofc_unit_inst_b (.i_clk(i_clk), .i_reset(i_reset),
      .link(link_b), .i_power_good(pg), .i_supply_fail(sf), .i_internal_fail(inf), .i_config_req(cfg),
      .i_chan_fail(cfail), .o_mode(mode2), .o_chan(chan2), .o_safe_output_request(sor2),
      .o_heartbeat(), .o_led_run(), .o_led_fault(), .o_display(), .o_err(err2));
   ofc_ctrl #(.EXCH_CYC(EXCH), .TMO_CYC(TMO)) ofc_ctrl_inst (.i_clk(i_clk), .i_reset(i_reset), .link(link),
      .i_cmd(cmd), .i_trip_req(trip), .o_comm_loss(loss), .o_trip_flag(tflag), .o_unit_mode(umode),
      .o_chan_failed(failed), .o_safe_subst(subst), .o_chan_eff(eff));
   ofc_sva #(.EXCH_CYC(EXCH)) ofc_sva_inst (.i_clk(i_clk), .i_reset(i_reset), .c2u_bit(link.c2u_bit),
      .c2u_frm(link.c2u_frm), .u2c_bit(link.u2c_bit), .u2c_frm(link.u2c_frm));

   task automatic end_sim();
      if (err_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_vec(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic chk_err(input logic [2:0] e);
      chk_vec("err", {29'h0, e}, {29'h0, err1});
   endtask
   task automatic wait_mode(input logic b, input ofc_mode_e m, input int lim);
      for (int i = 0; i < lim && (b ? mode2 : mode1) !== m; i++) begin
         step(1);
      end
      chk_vec(b ? "mode_b" : "mode", {29'h0, m}, {29'h0, b ? mode2 : mode1});
   endtask
   // far end driver: released data line shows the inverse of the last bit
   task automatic send_b(input logic [47:0] f);
      for (int i = 47; i >= 0; i--) begin
         link_b.c2u_frm = 2'b11;
         link_b.c2u_bit = {2{f[i]}};
         step(1);
      end
      link_b.c2u_frm = 2'b00;
      link_b.c2u_bit = {2{~f[0]}};
   endtask
   task automatic hb_count(output int c);
      logic h;
      c = 0;
      h = hb1;
      repeat (40) begin
         step(1);
         c += int'(hb1 !== h);
         h = hb1;
      end
   endtask
   function automatic logic [47:0] mk(input logic [7:0] t, input logic [31:0] d, input logic bad);
      return {t, d, crc8({t, d}) ^ {7'h0, bad}};
   endfunction
   function automatic logic [31:0] ecode(input logic [2:0] e);
      return {`OFC_TXT_ERR, `OFC_TXT_DIG + {5'h0, e}};
   endfunction

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #300000;
      err_count++;
      end_sim();
   end
   initial begin
      {i_reset, pg, sf, inf, cfg, trip} = 6'b10_0000;
      {cfail, cmd} = '0;
      link_b.c2u_frm = 2'b00;
      link_b.c2u_bit = 2'b00;
      p = $urandom(68990);
      step(5);
      i_reset = 1'b0;
      step(20);
      wait_mode(0, OFC_OFF, 1);
      chk_bit("u2c_frm", 1'b0, |link.u2c_frm);
      chk_vec("display", `OFC_TXT_OFF, disp1);
      pg = 1'b1;
      step(1);
      wait_mode(0, OFC_STARTUP, 1);
      send_b(mk(`OFC_TYP_CMD, 32'h0000_00FF, 1'b1));
      step(3);
      wait_mode(1, OFC_STARTUP, 1);
      p = $urandom;
      send_b(mk(`OFC_TYP_CMD, p, 1'b0));
      step(3);
      wait_mode(1, OFC_RUN, 1);
      chk_vec("chan_b", p, chan2);
      step(600);
      wait_mode(1, OFC_RUN, 1);
      wait_mode(1, OFC_SAFE, 200);
      chk_bit("sor_b", 1'b1, sor2);
      chk_vec("chan_b", 32'h0000_0000, chan2);
      chk_vec("err_b", {29'h0, `OFC_ERR_COMM}, {29'h0, err2});
      wait_mode(0, OFC_RUN, 700);
      for (int k = 0; k < 3; k++) begin
         cmd = (k == 0) ? $urandom : ((k == 1) ? 32'hFFFF_FFFF : 32'h0000_0001);
         step(500);
         chk_vec("chan", cmd, chan1);
      end
      chk_vec("display", `OFC_TXT_RUN, disp1);
      chk_bit("led_run", 1'b1, lr);
      chk_bit("led_fault", 1'b0, lf);
      chk_vec("unit_mode", {29'h0, OFC_RUN}, {29'h0, umode});
      cfg = 1'b1;
      wait_mode(0, OFC_CONFIG, 3);
      chk_vec("chan", 32'h0000_0000, chan1);
      cfg = 1'b0;
      wait_mode(0, OFC_STARTUP, 3);
      wait_mode(0, OFC_RUN, 300);
      mask = 32'h0000_0001 << ($urandom % 32);
      cmd = $urandom | mask;
      cfail = mask;
      step(700);
      chk_vec("chan_failed", mask, failed);
      chk_err(`OFC_ERR_CHAN);
      chk_vec("display", ecode(`OFC_ERR_CHAN), disp1);
      chk_bit("led_fault", 1'b1, lf);
      chk_vec("chan", cmd & ~mask, chan1);
      cfail = '0;
      step(500);
      chk_err(`OFC_ERR_CHAN);
      trip = 1'b1;
      wait_mode(0, OFC_SAFE, 500);
      chk_bit("sor", 1'b1, sor1);
      chk_vec("chan", 32'h0000_0000, chan1);
      step(2);
      chk_err(`OFC_ERR_TRIP);
      chk_bit("led_run", 1'b0, lr);
      chk_bit("subst", 1'b1, subst);
      chk_vec("chan_eff", 32'h0000_0000, eff);
      trip = 1'b0;
      step(500);
      wait_mode(0, OFC_SAFE, 1);
      chk_err(`OFC_ERR_TRIP);
      pg = 1'b0;
      step(1);
      wait_mode(0, OFC_OFF, 1);
      step(800);
      chk_err(`OFC_ERR_NONE);
      chk_bit("comm_loss", 1'b1, loss);
      chk_bit("trip_flag", 1'b1, tflag);
      pg = 1'b1;
      wait_mode(0, OFC_SAFE, 500);
      step(800);
      chk_bit("comm_loss", 1'b0, loss);
      pg = 1'b0;
      step(2);
      pg = 1'b1;
      wait_mode(0, OFC_RUN, 500);
      hb_count(n);
      chk_vec("hb_toggles", 32'h0000_0004, 32'(n));
      inf = 1'b1;
      step(2);
      hb_count(n);
      chk_vec("hb_toggles", 32'h0000_0000, 32'(n));
      chk_err(`OFC_ERR_INT);
      chk_vec("display", ecode(`OFC_ERR_INT), disp1);
      sf = 1'b1;
      wait_mode(0, OFC_FAULT, 3);
      chk_bit("sor", 1'b1, sor1);
      chk_vec("chan", 32'h0000_0000, chan1);
      step(2);
      chk_err(`OFC_ERR_SUPPLY);
      chk_vec("display", ecode(`OFC_ERR_SUPPLY), disp1);
      chk_bit("led_run", 1'b0, lr);
      chk_bit("led_fault", 1'b1, lf);
      end_sim();
   end
endmodule
